// file: hw/block_send_engine.sv
// Automatic block send engine with send-request abort handling, APB slave.
// Assumes a protocol core that arbitrates send_request by identifier and
// reports frame_start / frame_done pulses with the buffer number.
//
// The implementer's own choices: the register offsets and register access over APB.
module block_send_engine #(
  parameter int NBUF = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  input wire logic frame_done,
  input wire logic frame_ok,
  input wire logic [4:0] frame_buffer,
  output logic [NBUF-1:0] send_request,
  output logic history_record,
  output logic [4:0] history_buffer
);
  localparam int NB = block_send_pkg::BLOCK_BUFFERS;

  block_send_pkg::engine_state_t state;
  logic [2:0] operating_select;
  logic trigger;
  logic engine_clear;
  logic abort_pending;
  logic req_at_abort;
  logic [2:0] pointer;
  logic [7:0] gap_delay;
  logic [NB-1:0] buffer_armed;
  logic [7:0] prescale;
  logic [4:0] quanta;
  logic busy;
  logic [4:0] busy_buffer;
  logic [NBUF-1:0] abort_late;
  logic gap_done;

  // APB decode
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pready && pwrite;
  wire hit_mc = (paddr == block_send_pkg::OFF_MODULE_CONTROL);
  wire hit_bc = (paddr == block_send_pkg::OFF_BLOCK_SEND_CONTROL);
  wire hit_gd = (paddr == block_send_pkg::OFF_BLOCK_GAP_DELAY);
  wire hit_ba = (paddr == block_send_pkg::OFF_BUFFER_ARMED);
  wire hit_sr = (paddr == block_send_pkg::OFF_SEND_REQUEST);
  wire hit_bt = (paddr == block_send_pkg::OFF_BIT_TIMING_SETUP);
  wire mapped = hit_mc | hit_bc | hit_gd | hit_ba | hit_sr | hit_bt;
  wire block_mode = (operating_select == block_send_pkg::OPSEL_BLOCK);
  wire wr_trig_set = wr_acc && hit_bc && pwdata[block_send_pkg::TRIGGER_BIT];
  wire wr_trig_clr = wr_acc && hit_bc && !pwdata[block_send_pkg::TRIGGER_BIT];
  wire wr_clear = wr_acc && hit_bc && pwdata[block_send_pkg::ENGINE_CLEAR_BIT];

  // Frame completion seen for the buffer the engine is waiting on
  wire done_ok = frame_done && frame_ok;
  wire block_done = frame_done && (state == block_send_pkg::ENG_SEND) && (busy_buffer == {2'b00, pointer});
  wire [2:0] next_pointer = pointer + 3'h1;
  wire at_last = (pointer == block_send_pkg::LAST_BLOCK_BUFFER);
  wire armed_now = buffer_armed[pointer];
  wire start_ok = (state == block_send_pkg::ENG_IDLE) && trigger && block_mode && !engine_clear;
  wire gap_start = block_done && frame_ok && !at_last && !abort_pending;

  // Read mux: the engine exposes its pointer and the bus status
  wire [31:0] rd_mc = {23'h0, busy, 5'h00, operating_select};
  wire [31:0] rd_bc = {21'h0, pointer, 6'h00, engine_clear, trigger};
  wire [31:0] rd_bt = {19'h0, quanta, prescale};
  wire [31:0] rd_val = hit_mc ? rd_mc :
                       hit_bc ? rd_bc :
                       hit_gd ? {24'h0, gap_delay} :
                       hit_ba ? {24'h0, buffer_armed} :
                       hit_sr ? {{(32-NBUF){1'b0}}, send_request} :
                       hit_bt ? rd_bt : 32'h0;

  // No wait state: the answer is registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_val : 32'h0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operating_select <= block_send_pkg::OPSEL_INIT;
      gap_delay <= block_send_pkg::GAP_RESET;
      buffer_armed <= '0;
      prescale <= block_send_pkg::PRESCALE_RESET;
      quanta <= block_send_pkg::QUANTA_RESET;
    end else if (wr_acc) begin
      if (hit_mc) operating_select <= pwdata[block_send_pkg::OPSEL_LSB +: 3];
      if (hit_gd) gap_delay <= pwdata[7:0];
      if (hit_ba) buffer_armed <= pwdata[NB-1:0];
      if (hit_bt) begin
        prescale <= pwdata[block_send_pkg::PRESCALE_LSB +: 8];
        quanta <= pwdata[block_send_pkg::QUANTA_LSB +: 5];
      end
    end
  end

  // Bus status: which buffer the core has on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      busy_buffer <= 5'h00;
    end else if (frame_start) begin
      busy <= 1'b1;
      busy_buffer <= frame_buffer;
    end else if (frame_done) begin
      busy <= 1'b0;
    end
  end

  // Block engine sequencing, trigger and pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= block_send_pkg::ENG_IDLE;
      trigger <= 1'b0;
      engine_clear <= 1'b0;
      pointer <= block_send_pkg::POINTER_RESET;
      abort_pending <= 1'b0;
      req_at_abort <= 1'b0;
    end else begin
      if (engine_clear) begin
        engine_clear <= 1'b0;
        pointer <= block_send_pkg::POINTER_RESET;
      end else if (wr_clear && !trigger && state == block_send_pkg::ENG_IDLE) begin
        engine_clear <= 1'b1;
      end
      if (wr_trig_set && state == block_send_pkg::ENG_IDLE) begin
        trigger <= 1'b1;
      end
      unique case (state)
        block_send_pkg::ENG_IDLE: begin
          if (start_ok && armed_now) begin
            state <= block_send_pkg::ENG_SEND;
          end else if (start_ok) begin
            trigger <= 1'b0;
          end
          if (wr_trig_clr) trigger <= 1'b0;
        end
        block_send_pkg::ENG_SEND: begin
          if (wr_trig_clr && !abort_pending) begin
            abort_pending <= 1'b1;
            req_at_abort <= send_request[pointer];
          end
          if (block_done && frame_ok) begin
            pointer <= at_last ? block_send_pkg::POINTER_RESET : next_pointer;
            abort_pending <= 1'b0;
            if (at_last || abort_pending) begin
              trigger <= 1'b0;
              state <= block_send_pkg::ENG_IDLE;
            end else begin
              state <= block_send_pkg::ENG_GAP;
            end
          end else if (block_done && abort_pending) begin
            pointer <= req_at_abort ? pointer : next_pointer;
            abort_pending <= 1'b0;
            trigger <= 1'b0;
            state <= block_send_pkg::ENG_IDLE;
          end
        end
        block_send_pkg::ENG_GAP: begin
          if (wr_trig_clr) begin
            trigger <= 1'b0;
            state <= block_send_pkg::ENG_IDLE;
          end else if (gap_done && armed_now) begin
            state <= block_send_pkg::ENG_SEND;
          end else if (gap_done) begin
            trigger <= 1'b0;
            state <= block_send_pkg::ENG_IDLE;
          end
        end
      endcase
    end
  end

  // Gap between block requests, in data bit times
  bit_gap_timer #(.GAP_W(8)) gap_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(gap_start),
    .cancel(wr_trig_clr),
    .gap(gap_delay),
    .prescale(prescale),
    .quanta(quanta),
    .done(gap_done)
  );

  // Send request bits. The engine owns bits 0..7 in block mode and raises
  // only one at a time, so the core's identifier search never reorders the
  // block; the other buffers stay open to software and to that search.
  wire [NBUF-1:0] sw_set = (wr_acc && hit_sr) ? pwdata[NBUF-1:0] : '0;
  wire [NBUF-1:0] sw_clr = (wr_acc && hit_sr) ? ~pwdata[NBUF-1:0] & send_request : '0;
  wire eng_raise = (start_ok && armed_now) || (state == block_send_pkg::ENG_GAP && gap_done && armed_now
                   && !wr_trig_clr);
  wire eng_drop = block_done && (frame_ok || abort_pending);
  wire [NBUF-1:0] blk_mask = block_mode ? {{(NBUF-NB){1'b0}}, {NB{1'b1}}} : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_request <= '0;
      abort_late <= '0;
    end else begin
      for (int m = 0; m < NBUF; m++) begin
        if (eng_raise && m == int'(pointer) && block_mode) begin
          send_request[m] <= 1'b1;
        end else if (eng_drop && m == int'(pointer)) begin
          send_request[m] <= 1'b0;
        end else if (frame_done && busy_buffer == 5'(m) && (frame_ok || abort_late[m])) begin
          send_request[m] <= 1'b0;
          abort_late[m] <= 1'b0;
        end else if (sw_clr[m] && !blk_mask[m]) begin
          // A buffer already on the bus finishes its frame first
          if (busy && busy_buffer == 5'(m)) abort_late[m] <= 1'b1;
          else send_request[m] <= 1'b0;
        end else if (sw_set[m] && !blk_mask[m]) begin
          send_request[m] <= 1'b1;
        end
      end
    end
  end

  // In block mode, history list entries are only for buffers outside the block area
  wire from_block = block_mode && (busy_buffer < 5'(NB));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      history_record <= 1'b0;
      history_buffer <= 5'h00;
    end else begin
      history_record <= done_ok && !from_block;
      history_buffer <= done_ok ? busy_buffer : history_buffer;
    end
  end

  // Assertions
  trig_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == block_send_pkg::ENG_SEND && wr_trig_clr && !block_done) |=> trigger)
    else $error("trigger dropped during a block frame");
  last_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    (block_done && frame_ok && at_last) |=> !trigger && pointer == 3'h0)
    else $error("block did not end after buffer 7");
  one_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    block_mode |-> $countones(send_request[NB-1:0]) <= 1)
    else $error("more than one block request pending");
  disarm_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && !armed_now) |=> !trigger && $stable(pointer))
    else $error("disarmed buffer did not stop the block");
  clear_self_a: assert property (@(posedge pclk) disable iff (!presetn)
    engine_clear |=> !engine_clear && pointer == 3'h0)
    else $error("engine clear not completed");
  good_next_a: assert property (@(posedge pclk) disable iff (!presetn)
    (block_done && frame_ok && !at_last) |=> pointer == $past(next_pointer))
    else $error("pointer not advanced after good frame");
  bad_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    (block_done && !frame_ok && abort_pending && req_at_abort) |=> $stable(pointer) && !trigger)
    else $error("pointer moved after failed aborted frame");
  no_history_a: assert property (@(posedge pclk) disable iff (!presetn)
    (done_ok && from_block) |=> !history_record)
    else $error("block frame recorded in history");
  start_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start_ok && armed_now && pointer == 3'h0) |=> send_request[0])
    else $error("buffer 0 request not raised on trigger");
endmodule

// file: hw/block_send_pkg.sv
// Package for the automatic block send engine: register map, field layout,
// reset values and the operating mode codes.
// Assumes a 32-bit APB slave port with word-aligned register offsets.
package block_send_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_MODULE_CONTROL = 8'h00;
  localparam logic [7:0] OFF_BLOCK_SEND_CONTROL = 8'h04;
  localparam logic [7:0] OFF_BLOCK_GAP_DELAY = 8'h08;
  localparam logic [7:0] OFF_BUFFER_ARMED = 8'h0C;
  localparam logic [7:0] OFF_SEND_REQUEST = 8'h10;
  localparam logic [7:0] OFF_BIT_TIMING_SETUP = 8'h14;

  // Field positions
  localparam int OPSEL_LSB = 0;
  localparam int BUS_SEND_STATUS_BIT = 8;
  localparam int TRIGGER_BIT = 0;
  localparam int ENGINE_CLEAR_BIT = 1;
  localparam int POINTER_LSB = 8;
  localparam int PRESCALE_LSB = 0;
  localparam int QUANTA_LSB = 8;

  // Operating select codes
  localparam logic [2:0] OPSEL_INIT = 3'h0;
  localparam logic [2:0] OPSEL_BLOCK = 3'h2;

  // Block area and reset values
  localparam int BLOCK_BUFFERS = 8;
  localparam logic [2:0] LAST_BLOCK_BUFFER = 3'h7;
  localparam logic [2:0] POINTER_RESET = 3'h0;
  localparam logic [7:0] GAP_RESET = 8'h00;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [4:0] QUANTA_RESET = 5'h07;

  // Engine states
  typedef enum logic [1:0] {ENG_IDLE, ENG_SEND, ENG_GAP} engine_state_t;
endpackage

// file: hw/bit_gap_timer.sv
// Gap timer: counts a number of data bit times after a start pulse.
// Assumes the bit time is (prescale+1) clocks per quantum times (quanta+1) quanta.
module bit_gap_timer #(
  parameter int GAP_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic cancel,
  input wire logic [GAP_W-1:0] gap,
  input wire logic [7:0] prescale,
  input wire logic [4:0] quanta,
  output logic done
);
  logic running;
  logic [GAP_W-1:0] bits_left;
  logic [7:0] clk_cnt;
  logic [4:0] tq_cnt;
  wire tq_tick = (clk_cnt == prescale);
  wire bit_tick = tq_tick && (tq_cnt == quanta);
  wire last_bit = bit_tick && (bits_left == {{(GAP_W-1){1'b0}}, 1'b1});

  // A zero gap finishes on the very next edge so no bus time is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cancel) begin
        running <= 1'b0;
      end else if (start) begin
        running <= (gap != '0);
        done <= (gap == '0);
      end else if (running && last_bit) begin
        running <= 1'b0;
        done <= 1'b1;
      end
    end
  end

  // Prescale and quantum counters restart with each gap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cnt <= 8'h00;
      tq_cnt <= 5'h00;
      bits_left <= '0;
    end else if (start) begin
      clk_cnt <= 8'h00;
      tq_cnt <= 5'h00;
      bits_left <= gap;
    end else if (running) begin
      clk_cnt <= tq_tick ? 8'h00 : clk_cnt + 8'h01;
      if (tq_tick) begin
        tq_cnt <= bit_tick ? 5'h00 : tq_cnt + 5'h01;
      end
      if (bit_tick) begin
        bits_left <= bits_left - {{(GAP_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// file: test/can_node_model.sv
// Behavioural model of the protocol core and the other nodes on the CAN bus.
// Assumes the engine's clock; a frame is a count of clocks, not of bits.
module can_node_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] send_request,
  input wire logic hold,
  input wire logic fail_next,
  input wire logic [7:0] frame_len,
  output logic frame_start,
  output logic frame_done,
  output logic frame_ok,
  output logic [4:0] frame_buffer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [7:0] cnt;
  logic [1:0] cool;
  wire frame_end = busy && cnt == frame_len;

  // Identifiers are taken as equal, so the lowest pending buffer number wins
  function automatic logic [4:0] lowest(input logic [31:0] r);
    lowest = 5'h00;
    for (int i = 31; i >= 0; i--) if (r[i]) lowest = i[4:0];
  endfunction

  // Cool-down lets the engine drop a finished request before the next search
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_start <= 1'b0;
      frame_done <= 1'b0;
      frame_ok <= 1'b0;
      frame_buffer <= 5'h00;
      busy <= 1'b0;
      cnt <= 8'h00;
      cool <= 2'h0;
    end else begin
      frame_start <= !busy && cool == 2'h0 && !hold && send_request != 32'h0;
      frame_done <= frame_end;
      frame_ok <= frame_end ? ~fail_next : ~frame_ok; // Toggles outside frame_done, never stale
      cnt <= busy ? cnt + 8'h01 : 8'h00;
      if (busy) begin
        if (frame_end) begin
          busy <= 1'b0;
          cool <= 2'h3;
        end
      end else if (cool != 2'h0) begin
        cool <= cool - 2'h1;
        frame_buffer <= ~frame_buffer; // Released line shows a changing pattern
      end else if (!hold && send_request != 32'h0) begin
        busy <= 1'b1;
        frame_buffer <= lowest(send_request);
      end else begin
        frame_buffer <= ~frame_buffer;
      end
    end
  end
endmodule

// file: test/can_auto_block_transmit_abort_tb.sv
// Self-checking bench for the block send engine over APB, with a bus-node model.
// Assumes the register map and field positions of block_send_pkg.
module can_auto_block_transmit_abort_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MODE = block_send_pkg::OFF_MODULE_CONTROL;
  localparam logic [7:0] CTRL = block_send_pkg::OFF_BLOCK_SEND_CONTROL;
  localparam logic [7:0] GAP = block_send_pkg::OFF_BLOCK_GAP_DELAY;
  localparam logic [7:0] ARMED = block_send_pkg::OFF_BUFFER_ARMED;
  localparam logic [7:0] REQ = block_send_pkg::OFF_SEND_REQUEST;
  localparam logic [7:0] TIMING = block_send_pkg::OFF_BIT_TIMING_SETUP;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, frame_start, frame_done, frame_ok, history_record;
  logic [4:0] frame_buffer, history_buffer, hist_last;
  logic [31:0] send_request, d;
  logic hold = 1'b0;
  logic fail_next = 1'b0;
  logic [7:0] frame_len = 8'h06;
  logic [7:0] prev_req = 8'h00;
  logic e;
  logic [4:0] q[$];
  int num_errors = 0;
  int check_count = 0;
  int hist_cnt = 0;
  int gap_cnt = 0;
  int last_gap = 0;

  block_send_engine u_block_send_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .frame_done(frame_done), .frame_ok(frame_ok), .frame_buffer(frame_buffer),
    .send_request(send_request), .history_record(history_record), .history_buffer(history_buffer));
  can_node_model u_can_node_model (.pclk(pclk), .presetn(presetn), .send_request(send_request), .hold(hold),
    .fail_next(fail_next), .frame_len(frame_len), .frame_start(frame_start), .frame_done(frame_done),
    .frame_ok(frame_ok), .frame_buffer(frame_buffer));

  always #4 pclk = ~pclk;

  // Frame order, history pulses and the distance from frame end to next block request
  always @(posedge pclk) begin
    if (frame_start === 1'b1) q.push_back(frame_buffer);
    if (history_record === 1'b1) begin
      hist_cnt++;
      hist_last = history_buffer;
    end
    gap_cnt = (frame_done === 1'b1) ? 0 : gap_cnt + 1;
    if (send_request[7:0] != 8'h00 && prev_req == 8'h00) last_gap = gap_cnt;
    prev_req = send_request[7:0];
  end

  // Request held from setup until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) num_errors++; // A transfer with no answer counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, wd, r, x);
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [31:0] r);
    logic x;
    apb(1'b0, a, 32'h0, r, x);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Polls a register field; a bounded count keeps a stuck engine from hanging the run
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, output logic [31:0] r);
    int n;
    n = 0;
    do begin
      rdreg(a, r);
      n++;
    end while ((r & m) !== v && n < 400);
    if ((r & m) !== v) num_errors++; // Poll limit ran out
  endtask

  task automatic wait_start(input logic [4:0] b);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(frame_start === 1'b1 && frame_buffer === b) && n < 2000);
    if (!(frame_start === 1'b1 && frame_buffer === b)) num_errors++; // Frame never started
  endtask

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    print_verdict;
  end

  // Main sequence: mask 32'h703 keeps trigger, engine clear and pointer
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdreg(CTRL, d);
    check(d, 32'h0);
    apb(1'b0, 8'h20, 32'h0, d, e);
    check({31'h0, e}, 32'h1);
    check(d, 32'h0);
    wr(TIMING, 32'h0);
    wr(MODE, 32'h2);
    rdreg(MODE, d);
    check(d & 32'h7, 32'h2);
    wr(ARMED, 32'hFF);
    wr(CTRL, 32'h1);
    wait_reg(CTRL, 32'h1, 32'h0, d);
    check(d & 32'h703, 32'h0);
    check(q.size(), 8);
    for (int i = 0; i < 8; i++) check(q[i], i);
    check(hist_cnt, 0);
    // Bit time of 2 x 2 clocks, gap of 4 bit times
    wr(GAP, 32'h4);
    wr(TIMING, 32'h101);
    wr(CTRL, 32'h1);
    wait_reg(CTRL, 32'h1, 32'h0, d);
    check(last_gap >= 16 && last_gap <= 22, 1);
    wr(GAP, 32'h0);
    wr(TIMING, 32'h0);
    q.delete();
    wr(ARMED, 32'h07);
    wr(CTRL, 32'h1);
    wait_reg(CTRL, 32'h1, 32'h0, d);
    check(d & 32'h703, 32'h300);
    wr(ARMED, 32'h3F);
    wr(CTRL, 32'h1);
    wait_reg(CTRL, 32'h1, 32'h0, d);
    check(d & 32'h703, 32'h600);
    check(q.size(), 6);
    check(q[3], 3);
    wr(CTRL, 32'h2);
    rdreg(CTRL, d);
    check(d & 32'h703, 32'h0);
    q.delete();
    wr(ARMED, 32'hFF);
    wr(CTRL, 32'h1);
    wait_start(5'h07);
    wr(CTRL, 32'h0);
    wait_reg(CTRL, 32'h1, 32'h0, d);
    check(d & 32'h703, 32'h0);
    check(q[0], 0);
    // Abort while a block frame is on the bus
    frame_len <= 8'd40;
    wr(CTRL, 32'h1);
    wait_start(5'h00);
    wr(CTRL, 32'h0);
    rdreg(CTRL, d);
    check(d & 32'h1, 32'h1);
    rdreg(MODE, d);
    check(d & 32'h100, 32'h100);
    wait_reg(CTRL, 32'h1, 32'h0, d);
    check(d & 32'h703, 32'h100);
    rdreg(MODE, d);
    check(d & 32'h100, 32'h0);
    // Non-block requests: abort while pending, then arbitration beside a block request
    hold <= 1'b1;
    wr(REQ, 32'h400);
    rdreg(REQ, d);
    check(d, 32'h400);
    wr(REQ, 32'h0);
    rdreg(REQ, d);
    check(d, 32'h0);
    wr(CTRL, 32'h1);
    wr(REQ, 32'h100);
    rdreg(REQ, d);
    check(d, 32'h102);
    hold <= 1'b0;
    wait_reg(REQ, 32'hFFFFFFFF, 32'h0, d);
    check(hist_cnt, 1);
    check(hist_last, 8);
    // Erroneous frame with its request still set at the abort
    wr(CTRL, 32'h1);
    wait_start(5'h01);
    fail_next <= 1'b1;
    hold <= 1'b1;
    wr(CTRL, 32'h0);
    wait_reg(CTRL, 32'h1, 32'h0, d);
    check(d & 32'h703, 32'h100);
    print_verdict;
  end
endmodule
